// *** dhsm_core.sv ***
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "dhsm_map.svh"
// Functional notes
// RQ1: Register shift amount is low five bits, signed -16..+15; upper bits ignored.
// RQ2: Register-driven arithmetic shift has an optional saturation select.
// RQ3: Saturated left shift losing non-sign bits clamps to 0x7FFF or 0x8000 by sign.
// RQ4: Arithmetic right shifts refill upper bits with the half's sign bit.
// RQ5: Arithmetic register shift: positive left (saturating if selected), negative right.
// RQ6: Register shift amount comes from the low half of a data register, both halves.
// RQ7: Immediate shifts use an unsigned four-bit count 0..15.
// RQ8: Both halves shift together but independently; no bits cross halves.
// RQ9: Logical shifts drop shifted-out bits and fill with zeros.
// RQ10: Logical register shift: positive shifts left, negative shifts right.
// RQ11: Sources stay unchanged unless the destination index equals a source index.
// RQ12: Vector max picks the larger signed 16-bit value per half.
// RQ13: Vector min picks the more negative signed 16-bit value per half.
// RQ14: Zero flag set if either half is zero; negative flag if either negative.
// RQ15: Arithmetic shifts set overflow if either half overflows; sticky follows overflow.
// RQ16: Logical, max, min clear overflow; unnamed flags remain unchanged.
// RQ17: Operation and saturation decoded from command; result and flags in one cycle.

module dhsm_core
	import dhsm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`DHSM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`DHSM_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`DHSM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`DHSM_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);

	// ============================================================
	// Decoding helpers
	function automatic logic [3:0] dhsm_sel(input logic [`DHSM_ADDR_W-1:0] a);
		logic [3:0] s;
		s = `DHSM_SEL_NONE;
		if (a[1:0] == 2'h0) begin
			if (a < `DHSM_OFS_CMD) begin
				s = {1'b0, a[4:2]};
			end else if (a == `DHSM_OFS_CMD) begin
				s = `DHSM_SEL_CMD;
			end else if (a == `DHSM_OFS_FLAGS) begin
				s = `DHSM_SEL_FLAGS;
			end else if (a == `DHSM_OFS_IRQ_STATUS) begin
				s = `DHSM_SEL_IRQ_STATUS;
			end else if (a == `DHSM_OFS_IRQ_MASK) begin
				s = `DHSM_SEL_IRQ_MASK;
			end else if (a == `DHSM_OFS_RESULT) begin
				s = `DHSM_SEL_RESULT;
			end
		end
		return s;
	endfunction : dhsm_sel

	function automatic logic [31:0] dhsm_strb(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : dhsm_strb

	// Arithmetic shift of one half; bit 16 of the return is the overflow
	function automatic logic [16:0] dhsm_ash(input dhsm_half_t x, input logic signed [5:0] amt,
		input logic sat);
		logic [31:0] ext;
		logic [31:0] sh;
		logic [4:0] d;
		logic ov;
		dhsm_half_t r;
		ext = {{16{x[15]}}, x};
		if (amt < 0) begin
			d = 5'(-amt);
			sh = 32'($signed(ext) >>> d); // see RQ4
			ov = 1'b0;
			r = sh[15:0];
		end else begin
			d = 5'(amt);
			sh = ext << d;
			// Any top bit differing from the sign means a non-sign bit was lost
			ov = (sh[31:15] != {17{x[15]}});
			if (ov && sat) begin
				r = x[15] ? `DHSM_HALF_MIN : `DHSM_HALF_MAX; // see RQ3
			end else begin
				r = sh[15:0];
			end
		end
		return {ov, r};
	endfunction : dhsm_ash

	function automatic dhsm_half_t dhsm_lsh(input dhsm_half_t x, input logic signed [5:0] amt);
		logic [31:0] sh;
		if (amt < 0) begin
			sh = {16'h0000, x} >> 5'(-amt); // see RQ9
		end else begin
			sh = {16'h0000, x} << 5'(amt); // see RQ9
		end
		return sh[15:0];
	endfunction : dhsm_lsh

	// ============================================================
	// State
	logic [31:0] dreg [`DHSM_NUM_DREGS];
	logic [3:0] flags;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [31:0] last_result;
	// Command readback must not follow later writes to other registers
	logic [31:0] last_cmd;
	logic aw_held;
	logic w_held;
	logic [`DHSM_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// ============================================================
	// Write channel
	logic do_wr;
	logic [3:0] wsel;
	logic exec;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_wr = aw_held && w_held && !s_axi_bvalid;
	assign wsel = dhsm_sel(aw_addr_q);
	assign exec = do_wr && (wsel == `DHSM_SEL_CMD);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= `DHSM_RST_WORD;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_wr) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DHSM_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wsel == `DHSM_SEL_NONE) ? `DHSM_RESP_SLVERR : `DHSM_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ============================================================
	// Command decode and datapath
	dhsm_op_t op;
	logic [2:0] dest_idx;
	logic [31:0] src_a;
	logic [31:0] src_b;
	logic [3:0] imm_shift_count;
	logic sat;
	logic [4:0] data_register_low_half;
	logic signed [5:0] amt;
	logic arith_op;
	logic [31:0] result;
	logic [1:0] half_ov;

	assign op = dhsm_op_t'(w_data_q[`DHSM_CMD_OP_LSB +: 3]); // see RQ17
	assign dest_idx = w_data_q[`DHSM_CMD_DEST_LSB +: 3];
	assign src_a = dreg[w_data_q[`DHSM_CMD_SRC0_LSB +: 3]];
	assign src_b = dreg[w_data_q[`DHSM_CMD_SRC1_LSB +: 3]];
	assign imm_shift_count = w_data_q[`DHSM_CMD_IMM_LSB +: 4]; // see RQ7
	assign sat = w_data_q[`DHSM_CMD_SAT_BIT]; // see RQ2
	// Only five bits are kept, so larger magnitudes wrap into range
	assign data_register_low_half = src_b[4:0]; // see RQ1, RQ6

	always_comb begin
		amt = 6'sd0;
		arith_op = 1'b0;
		case (op)
			DHSM_OP_ASR_IMM: begin
				amt = -$signed({2'b00, imm_shift_count});
				arith_op = 1'b1;
			end
			DHSM_OP_ASL_IMM: begin
				amt = $signed({2'b00, imm_shift_count});
				arith_op = 1'b1;
			end
			DHSM_OP_ASHIFT_REG: begin
				amt = $signed({data_register_low_half[4], data_register_low_half}); // see RQ5
				arith_op = 1'b1;
			end
			DHSM_OP_LSR_IMM: amt = -$signed({2'b00, imm_shift_count});
			DHSM_OP_LSL_IMM: amt = $signed({2'b00, imm_shift_count});
			DHSM_OP_LOGIC_SHIFT_BY_REG_REG: begin
				amt = $signed({data_register_low_half[4], data_register_low_half}); // see RQ10
			end
			default: amt = 6'sd0;
		endcase
	end

	// Each half's data comes from its own 16 bits; register shift amounts use src_b[4:0] for both halves
	for (genvar h = 0; h < 2; h++) begin : g_half // see RQ8
		dhsm_half_t a_h;
		dhsm_half_t b_h;
		logic [16:0] ash_h;
		dhsm_half_t res_h;
		assign a_h = src_a[16*h +: 16];
		assign b_h = src_b[16*h +: 16];
		assign ash_h = dhsm_ash(a_h, amt, sat);
		always_comb begin
			case (op)
				DHSM_OP_ASR_IMM, DHSM_OP_ASL_IMM, DHSM_OP_ASHIFT_REG: res_h = ash_h[15:0];
				DHSM_OP_LSR_IMM, DHSM_OP_LSL_IMM, DHSM_OP_LOGIC_SHIFT_BY_REG_REG: res_h = dhsm_lsh(a_h, amt);
				DHSM_OP_MAX: res_h = ($signed(a_h) > $signed(b_h)) ? a_h : b_h; // see RQ12
				DHSM_OP_MIN: res_h = ($signed(a_h) < $signed(b_h)) ? a_h : b_h; // see RQ13
				default: res_h = a_h;
			endcase
		end
		assign result[16*h +: 16] = res_h;
		assign half_ov[h] = arith_op && ash_h[16];
	end

	// ============================================================
	// Data register file
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `DHSM_NUM_DREGS; i++) begin
				dreg[i] <= `DHSM_RST_WORD;
			end
		end else begin
			for (int i = 0; i < `DHSM_NUM_DREGS; i++) begin
				if (do_wr && wsel == 4'(i)) begin
					dreg[i] <= dhsm_strb(dreg[i], w_data_q, w_strb_q);
				end else if (exec && dest_idx == 3'(i)) begin
					dreg[i] <= result; // see RQ11
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_result <= `DHSM_RST_WORD;
			last_cmd <= `DHSM_RST_WORD;
		end else if (exec) begin
			last_result <= result;
			last_cmd <= w_data_q; // see RQ17
		end
	end

	// ============================================================
	// Status flags
	logic sticky_overflow_flag;
	logic zero_flag;
	logic negative_flag;
	logic sticky_clr;

	assign zero_flag = (result[15:0] == 16'h0000) || (result[31:16] == 16'h0000);
	assign negative_flag = result[15] || result[31];
	assign sticky_overflow_flag = flags[`DHSM_FLAG_STICKY];
	assign sticky_clr = do_wr && (wsel == `DHSM_SEL_FLAGS) && w_strb_q[0]
		&& w_data_q[`DHSM_FLAG_STICKY];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= `DHSM_RST_FLAGS;
		end else if (exec) begin
			flags[`DHSM_FLAG_ZERO] <= zero_flag; // see RQ14
			flags[`DHSM_FLAG_NEG] <= negative_flag; // see RQ14
			flags[`DHSM_FLAG_OV] <= |half_ov; // see RQ15, RQ16
			flags[`DHSM_FLAG_STICKY] <= sticky_overflow_flag || (|half_ov); // see RQ15
		end else if (sticky_clr) begin
			flags[`DHSM_FLAG_STICKY] <= 1'b0;
		end
	end

	// ============================================================
	// Interrupts
	logic [1:0] irq_events;
	logic [1:0] irq_clr;

	assign irq_events = {|half_ov && exec, exec};
	assign irq_clr = (do_wr && wsel == `DHSM_SEL_IRQ_STATUS && w_strb_q[0]) ? w_data_q[1:0] : 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= `DHSM_RST_IRQ;
		end else begin
			// Set beats clear so a simultaneous event survives
			irq_status <= (irq_status & ~irq_clr) | irq_events;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= `DHSM_RST_IRQ;
		end else if (do_wr && wsel == `DHSM_SEL_IRQ_MASK && w_strb_q[0]) begin
			irq_mask <= w_data_q[1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ============================================================
	// Read channel
	logic [3:0] rsel;
	logic [31:0] rword;

	assign s_axi_arready = !s_axi_rvalid;
	assign rsel = dhsm_sel(s_axi_araddr);

	always_comb begin
		rword = `DHSM_RST_WORD;
		case (rsel)
			`DHSM_SEL_CMD: rword = last_cmd;
			`DHSM_SEL_FLAGS: rword = {28'h0, flags};
			`DHSM_SEL_IRQ_STATUS: rword = {30'h0, irq_status};
			`DHSM_SEL_IRQ_MASK: rword = {30'h0, irq_mask};
			`DHSM_SEL_RESULT: rword = last_result;
			`DHSM_SEL_NONE: rword = `DHSM_RST_WORD;
			default: rword = dreg[rsel[2:0]];
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `DHSM_RST_WORD;
			s_axi_rresp <= `DHSM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rword;
			s_axi_rresp <= (rsel == `DHSM_SEL_NONE) ? `DHSM_RESP_SLVERR : `DHSM_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : dhsm_core

// *** dhsm_map.svh ***
`ifndef DHSM_MAP_SVH
`define DHSM_MAP_SVH

// ============================================================
// Bus geometry
`define DHSM_ADDR_W 8
`define DHSM_DATA_W 32
`define DHSM_NUM_DREGS 8

// ============================================================
// Register byte offsets
`define DHSM_OFS_DREG0 8'h00
`define DHSM_OFS_CMD 8'h20
`define DHSM_OFS_FLAGS 8'h24
`define DHSM_OFS_IRQ_STATUS 8'h28
`define DHSM_OFS_IRQ_MASK 8'h2C
`define DHSM_OFS_RESULT 8'h30

// ============================================================
// Register selector codes
`define DHSM_SEL_CMD 4'h8
`define DHSM_SEL_FLAGS 4'h9
`define DHSM_SEL_IRQ_STATUS 4'hA
`define DHSM_SEL_IRQ_MASK 4'hB
`define DHSM_SEL_RESULT 4'hC
`define DHSM_SEL_NONE 4'hF

// ============================================================
// Command word fields
`define DHSM_CMD_OP_LSB 0
`define DHSM_CMD_DEST_LSB 4
`define DHSM_CMD_SRC0_LSB 8
`define DHSM_CMD_SRC1_LSB 12
`define DHSM_CMD_IMM_LSB 16
`define DHSM_CMD_SAT_BIT 20

// ============================================================
// Flag and interrupt bit positions
`define DHSM_FLAG_ZERO 0
`define DHSM_FLAG_NEG 1
`define DHSM_FLAG_OV 2
`define DHSM_FLAG_STICKY 3
`define DHSM_IRQ_DONE 0
`define DHSM_IRQ_OV 1

// ============================================================
// Reset values and limits
`define DHSM_RST_WORD 32'h0000_0000
`define DHSM_RST_FLAGS 4'h0
`define DHSM_RST_IRQ 2'h0
`define DHSM_HALF_MAX 16'h7FFF
`define DHSM_HALF_MIN 16'h8000
`define DHSM_RESP_OKAY 2'h0
`define DHSM_RESP_SLVERR 2'h2

`endif

// *** dhsm_pkg.sv ***
package dhsm_pkg;

	typedef enum logic [2:0] {
		DHSM_OP_ASR_IMM,
		DHSM_OP_ASL_IMM,
		DHSM_OP_ASHIFT_REG,
		DHSM_OP_LSR_IMM,
		DHSM_OP_LSL_IMM,
		DHSM_OP_LOGIC_SHIFT_BY_REG_REG,
		DHSM_OP_MAX,
		DHSM_OP_MIN
	} dhsm_op_t;

	typedef logic [15:0] dhsm_half_t;

endpackage : dhsm_pkg

// *** dhsm_core_assertions.sv ***
`timescale 1ns/1ns
// ==========
// Bus timing checks
module dhsm_core_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_hs; s_axi_arvalid && s_axi_arready; endsequence
	sequence aw_hs; s_axi_awvalid && s_axi_awready; endsequence
	sequence w_hs; s_axi_wvalid && s_axi_wready; endsequence
	chk_read_answer: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_write_answer: assert property (aw_hs and w_hs |=> ##[0:1] s_axi_bvalid)
		else $error("write answer late");
	chk_hole_read: assert property (ar_hs ##0 s_axi_araddr >= 8'h34 |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("hole read answered");
	chk_reset_quiet: assert property ($rose(aresetn) |->
		!s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
endmodule : dhsm_core_assertions

bind dhsm_core dhsm_core_assertions u_chk (.*);

// *** dhsm_axi_master.sv ***
`timescale 1ns/1ns
// ==========
// Bus master in the decoder's place
module dhsm_axi_master (
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				r = s_axi_bresp;
			end
		end while (s_axi_bready);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end while (s_axi_rready);
	endtask : rd
endmodule : dhsm_axi_master

// *** dual_halfword_shift_minmax_tb_top.sv ***
`timescale 1ns/1ns
`include "dhsm_map.svh"
module dual_halfword_shift_minmax_tb_top import dhsm_pkg::*; ;
	logic aclk, aresetn, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] m [8];
	dhsm_core dut (.*);
	dhsm_axi_master u_m (.*);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	// ==========
	// Reference model of one half
	function automatic logic [16:0] half(logic [2:0] op, dhsm_half_t x, dhsm_half_t y,
		logic [3:0] k, logic sat);
		int v, n, f;
		v = $signed(x);
		n = (op == 2 || op == 5) ? int'($signed(y[4:0])) : ((op == 0 || op == 3) ? -int'(k) : int'(k));
		if (op == 6) return {1'b0, $signed(x) > $signed(y) ? x : y};
		if (op == 7) return {1'b0, $signed(x) < $signed(y) ? x : y};
		if (op > 2) return {1'b0, n < 0 ? x >> (-n) : x << n};
		if (n < 0) return {1'b0, 16'(v >>> (-n))};
		f = v <<< n;
		if (f > 32767 || f < -32768) return {1'b1, sat ? (v < 0 ? 16'h8000 : 16'h7FFF) : 16'(f)};
		return {1'b0, 16'(f)};
	endfunction : half
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done;
		end
	end
	// ==========
	// Main sequence
	initial begin
		logic [31:0] d, c, cw;
		logic [16:0] hi, lo;
		logic [3:0] fl;
		logic [1:0] rs, st, mk;
		logic [2:0] op, ds, s0, s1;
		aresetn = 1'b0;
		void'($urandom(74));
		fl = 4'h0;
		st = 2'h0;
		m = '{default: 32'h0};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 13; i++) begin
			u_m.rd(8'(4 * i), d, rs);
			cmp(d, 32'h0);
		end
		$display("reset test done");
		for (int t = 0; t < 200; t++) begin
			op = 3'(t);
			ds = 3'($urandom);
			s0 = 3'($urandom);
			s1 = 3'($urandom);
			c = $urandom;
			m[s0] = $urandom;
			if (t % 3 == 0) m[s0][15:0] = 16'h0000;
			u_m.wr(8'({s0, 2'b00}), m[s0], rs);
			m[s1] = $urandom;
			if (t % 4 == 0) m[s1][4:0] = t[3] ? 5'h10 : 5'h0F;
			u_m.wr(8'({s1, 2'b00}), m[s1], rs);
			if (t % 7 == 0) begin
				u_m.wr(`DHSM_OFS_FLAGS, 32'h8, rs);
				fl[3] = 1'b0;
			end
			mk = 2'($urandom);
			u_m.wr(`DHSM_OFS_IRQ_MASK, 32'(mk), rs);
			cw = {11'h000, c[20:16], 1'b0, s1, 1'b0, s0, 1'b0, ds, 1'b0, op};
			u_m.wr(`DHSM_OFS_CMD, cw, rs);
			cmp(32'(rs), 32'(`DHSM_RESP_OKAY));
			hi = half(op, m[s0][31:16], op > 5 ? m[s1][31:16] : m[s1][15:0], c[19:16], c[20]);
			lo = half(op, m[s0][15:0], m[s1][15:0], c[19:16], c[20]);
			m[ds] = {hi[15:0], lo[15:0]};
			fl[2:0] = {hi[16] | lo[16], hi[15] | lo[15], hi[15:0] == 0 || lo[15:0] == 0};
			fl[3] = fl[3] | fl[2];
			st = st | {fl[2], 1'b1};
			cmp(irq, 32'(|(st & mk)));
			u_m.rd(8'({ds, 2'b00}), d, rs);
			cmp(d, m[ds]);
			cmp(32'(rs), 32'(`DHSM_RESP_OKAY));
			u_m.rd(`DHSM_OFS_RESULT, d, rs);
			cmp(d, m[ds]);
			u_m.rd(`DHSM_OFS_FLAGS, d, rs);
			cmp(d, 32'(fl));
			u_m.rd(8'({s0, 2'b00}), d, rs);
			cmp(d, m[s0]);
			c = $urandom;
			u_m.wr(`DHSM_OFS_IRQ_STATUS, 32'(c[1:0]), rs);
			st = st & ~c[1:0];
			u_m.rd(`DHSM_OFS_IRQ_STATUS, d, rs);
			cmp(d, 32'(st));
			cmp(irq, 32'(|(st & mk)));
		end
		$display("op test done");
		u_m.rd(`DHSM_OFS_CMD, d, rs);
		cmp(d, cw);
		u_m.wr(8'h34, 32'h1, rs);
		cmp(32'(rs), 32'(`DHSM_RESP_SLVERR));
		u_m.rd(8'h34, d, rs);
		cmp(d, 32'h0);
		cmp(32'(rs), 32'(`DHSM_RESP_SLVERR));
		u_m.wr(8'h01, 32'hFFFF_FFFF, rs);
		cmp(32'(rs), 32'(`DHSM_RESP_SLVERR));
		u_m.rd(8'h00, d, rs);
		cmp(d, m[0]);
		$display("bus test done");
		test_done;
	end
endmodule : dual_halfword_shift_minmax_tb_top
